/* rtl/revalid_pkg.sv */
/*
 * Shared constants for the reference input re-validation monitor: register
 * offsets, field positions, reset values and the divider and count tables.
 * Assumes a single core clock domain and an 8-bit register port.
 */
package revalid_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REF = 4;
    localparam int REVAL_W = 9;      // holds 256
    localparam int PRESC_W = 17;     // holds 2^17 - 1
    localparam int HOLD_W = 8;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_HOLDOFF = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_PWRDN = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h05;

    // ----------------------------------------------------------------
    // control field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIV_LSB = 2;
    localparam int CTRL_CNT_LSB = 4;
    localparam int CTRL_QUAD_BIT = 6;
    localparam int CTRL_MASK_BIT = 7;
    localparam int ST_LIVE_BIT = 4;
    localparam int ST_STICKY_BIT = 5;
    localparam int IRQ_FAIL_BIT = 4;
    localparam int IRQ_UNLOCK_BIT = 5;

    // ----------------------------------------------------------------
    // reset values and the auto-with-holdover mode code
    // ----------------------------------------------------------------
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [1:0] RST_DIV_SEL = 2'h2;
    localparam logic [1:0] RST_CNT_SEL = 2'h2;
    localparam logic [HOLD_W-1:0] RST_HOLDOFF = 8'h80;
    localparam logic [NUM_REF-1:0] RST_PWRDN = 4'h0;
    localparam logic [1:0] MODE_AUTO_HOLD = 2'h3;

    // ----------------------------------------------------------------
    // prescaler terminal counts (divide minus one)
    // ----------------------------------------------------------------
    localparam logic [PRESC_W-1:0] PRESC_DIV15 = 17'h07fff;
    localparam logic [PRESC_W-1:0] PRESC_DIV16 = 17'h0ffff;
    localparam logic [PRESC_W-1:0] PRESC_DIV17 = 17'h1ffff;

    // ----------------------------------------------------------------
    // re-validation period counts
    // ----------------------------------------------------------------
    localparam logic [REVAL_W-1:0] RV_2 = 9'h002;
    localparam logic [REVAL_W-1:0] RV_8 = 9'h008;
    localparam logic [REVAL_W-1:0] RV_16 = 9'h010;
    localparam logic [REVAL_W-1:0] RV_32 = 9'h020;
    localparam logic [REVAL_W-1:0] RV_64 = 9'h040;
    localparam logic [REVAL_W-1:0] RV_128 = 9'h080;
    localparam logic [REVAL_W-1:0] RV_256 = 9'h100;

endpackage : revalid_pkg

/* rtl/ref_input_revalidation_monitor.sv */
/*
 * Reference input monitor: per-input re-validation counters that release the
 * loss-of-signal flags, the hold-off timer with its reference prescaler,
 * per-input power-down controls, loss-of-lock status and an interrupt.
 * Assumes all inputs are synchronous to CORE_CLK_I; VCXO_PULSE_I marks one
 * VCXO-PLL output period, the per-input strobes come from edge detectors
 * outside this block, and the selection state machine lives elsewhere.
 */
// Strobed register access and the register addresses were chosen for this implementation.
// How it works
// - hold-off tick is VCXO pulses divided by 2^15, 2^16 or 2^17 per select
// - loss-of-signal loads the input counter; each valid period decrements it
// - a missing edge during re-validation reloads the programmed count
// - counter reaching zero re-validates the input and clears its flag
// - count select picks 2/16/32/64, or 8/64/128/256 with quad scale
// - four power-down bits, zero enables, one disables, all reset to zero
// - mask clear: unlock status on pll unlock or selected reference inactive
// - mask set: only pll unlock drives status and the lock pin
// - in auto-with-holdover the timer counts down, fails over, then reloads
// - hold-off period is the eight-bit value times the prescaler tick
`timescale 1ns/10ps
module ref_input_revalidation_monitor
    import revalid_pkg::*;
#(
    parameter int NUM_INPUTS = NUM_REF
)
(
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DATA_W-1:0] RDATA_O,
    input wire logic VCXO_PULSE_I,
    input wire logic [NUM_REF-1:0] LOS_EVENT_I,
    input wire logic [NUM_REF-1:0] REF_PERIOD_OK_I,
    input wire logic [NUM_REF-1:0] REF_EDGE_MISS_I,
    input wire logic [1:0] REF_SEL_I,
    input wire logic PLL_UNLOCK_I,
    output logic [NUM_REF-1:0] LOS_FLAG_O,
    output logic [NUM_REF-1:0] REF_PWRDN_O,
    output logic [1:0] REF_MODE_O,
    output logic FAILOVER_O,
    output logic UNLOCK_LIVE_N_O,
    output logic UNLOCK_STICKY_N_O,
    output logic LOCK_O,
    output logic IRQ_O
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // the register layout has exactly four input slots
    if (NUM_INPUTS != NUM_REF) begin : g_bad_inputs
        $error("NUM_INPUTS must equal four");
    end

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [PRESC_W-1:0] presc_limit(input logic [1:0] sel);
        logic [PRESC_W-1:0] lim;
        lim = PRESC_DIV17;
        unique case (sel)
            2'h0: lim = PRESC_DIV15;
            2'h1: lim = PRESC_DIV16;
            default: lim = PRESC_DIV17; // code 11 undefined, treat as 2^17
        endcase
        return lim;
    endfunction : presc_limit

    function automatic logic [REVAL_W-1:0] reval_count(input logic [1:0] sel,
                                                       input logic quad);
        logic [REVAL_W-1:0] n;
        n = RV_2;
        unique case ({quad, sel})
            3'h0: n = RV_2;
            3'h1: n = RV_16;
            3'h2: n = RV_32;
            3'h3: n = RV_64;
            3'h4: n = RV_8;
            3'h5: n = RV_64;
            3'h6: n = RV_128;
            3'h7: n = RV_256;
        endcase
        return n;
    endfunction : reval_count

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [1:0] ref_select_mode;
    logic [1:0] holdoff_ref_div_sel;
    logic [1:0] revalid_count_sel;
    logic revalid_quad_scale;
    logic refloss_mask;
    logic [HOLD_W-1:0] holdoff_period_value;
    logic [NUM_REF-1:0] ref_powerdown;
    logic [DATA_W-1:0] irq_mask;
    logic [DATA_W-1:0] irq_stat;
    logic [NUM_REF-1:0] los_flag;
    logic [NUM_REF-1:0] revalid_evt;
    logic [REVAL_W-1:0] reval_cnt [NUM_REF];
    logic [PRESC_W-1:0] presc_cnt;
    logic [HOLD_W-1:0] holdoff_cnt;
    logic holdoff_run;
    logic holdoff_tick;
    logic failover;
    logic unlock_cond;
    logic unlock_prev;
    logic vcxo_pll_unlock_sticky_n;
    logic [REVAL_W-1:0] reval_load;
    logic wr_ctrl;
    logic rd_irq;
    logic wr_status;

    assign wr_ctrl = WR_I && (ADDR_I == OFS_CTRL);
    assign rd_irq = RD_I && (ADDR_I == OFS_IRQ_STAT);
    assign wr_status = WR_I && (ADDR_I == OFS_STATUS);
    assign reval_load = reval_count(revalid_count_sel, revalid_quad_scale);

    // control register; divider and count selects steer the counters
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I)
        begin
            ref_select_mode <= RST_MODE;
            holdoff_ref_div_sel <= RST_DIV_SEL;
            revalid_count_sel <= RST_CNT_SEL;
            revalid_quad_scale <= 1'b0;
            refloss_mask <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            ref_select_mode <= WDATA_I[CTRL_MODE_LSB +: 2];
            holdoff_ref_div_sel <= WDATA_I[CTRL_DIV_LSB +: 2];
            revalid_count_sel <= WDATA_I[CTRL_CNT_LSB +: 2];
            revalid_quad_scale <= WDATA_I[CTRL_QUAD_BIT];
            refloss_mask <= WDATA_I[CTRL_MASK_BIT];
        end
    end

    // hold-off value, power-down bits and interrupt mask
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I)
        begin
            holdoff_period_value <= RST_HOLDOFF;
            ref_powerdown <= RST_PWRDN;
            irq_mask <= '0;
        end
        else if (WR_I)
        begin
            if (ADDR_I == OFS_HOLDOFF)
            begin
                holdoff_period_value <= WDATA_I;
            end
            if (ADDR_I == OFS_PWRDN)
            begin
                ref_powerdown <= WDATA_I[NUM_REF-1:0];
            end
            if (ADDR_I == OFS_IRQ_MASK)
            begin
                irq_mask <= WDATA_I;
            end
        end
    end

    // ----------------------------------------------------------------
    // re-validation counters
    // ----------------------------------------------------------------
    // one counter per input; a powered-down input is held lost and ignores
    // its strobes, since its detector output means nothing while disabled
    for (genvar i = 0; i < NUM_REF; i++) begin : g_reval
        always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
            if (!NRST_I)
            begin
                reval_cnt[i] <= '0;
                los_flag[i] <= 1'b0;
                revalid_evt[i] <= 1'b0;
            end
            else
            begin
                revalid_evt[i] <= 1'b0;
                if (ref_powerdown[i] || LOS_EVENT_I[i])
                begin
                    los_flag[i] <= 1'b1; // loss wins over a same-cycle release
                    reval_cnt[i] <= reval_load;
                end
                else if (los_flag[i])
                begin
                    if (REF_EDGE_MISS_I[i])
                    begin
                        reval_cnt[i] <= reval_load;
                    end
                    else if (REF_PERIOD_OK_I[i])
                    begin
                        reval_cnt[i] <= reval_cnt[i] - 9'h001;
                        if (reval_cnt[i] == 9'h001)
                        begin
                            los_flag[i] <= 1'b0;
                            revalid_evt[i] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // hold-off timer
    // ----------------------------------------------------------------
    // prescaler free-runs on VCXO pulses so the first tick lands anywhere
    // inside one tick period; the hold-off time is accurate to one tick
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I)
        begin
            presc_cnt <= '0;
        end
        else if (VCXO_PULSE_I)
        begin
            if (presc_cnt >= presc_limit(holdoff_ref_div_sel))
            begin
                presc_cnt <= '0;
            end
            else
            begin
                presc_cnt <= presc_cnt + 17'h00001;
            end
        end
    end

    assign holdoff_tick = VCXO_PULSE_I && (presc_cnt >= presc_limit(holdoff_ref_div_sel));

    // timer starts on loss of the selected input, fails over at zero
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I)
        begin
            holdoff_cnt <= RST_HOLDOFF;
            holdoff_run <= 1'b0;
            failover <= 1'b0;
        end
        else
        begin
            failover <= 1'b0;
            if (ref_select_mode != MODE_AUTO_HOLD)
            begin
                holdoff_run <= 1'b0;
                holdoff_cnt <= holdoff_period_value;
            end
            else if (!holdoff_run)
            begin
                holdoff_cnt <= holdoff_period_value;
                holdoff_run <= LOS_EVENT_I[REF_SEL_I];
            end
            else if (holdoff_tick)
            begin
                if (holdoff_cnt <= 8'h01)
                begin
                    failover <= 1'b1;
                    holdoff_run <= 1'b0;
                    holdoff_cnt <= holdoff_period_value;
                end
                else
                begin
                    holdoff_cnt <= holdoff_cnt - 8'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // loss-of-lock status
    // ----------------------------------------------------------------
    assign unlock_cond = PLL_UNLOCK_I || (los_flag[REF_SEL_I] && !refloss_mask);

    // sticky bit falls on unlock and rises on a status write; unlock wins
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I)
        begin
            vcxo_pll_unlock_sticky_n <= 1'b1;
            unlock_prev <= 1'b0;
        end
        else
        begin
            unlock_prev <= unlock_cond;
            if (unlock_cond)
            begin
                vcxo_pll_unlock_sticky_n <= 1'b0;
            end
            else if (wr_status)
            begin
                vcxo_pll_unlock_sticky_n <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    // read clears; a new event in the reading cycle stays set
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I)
        begin
            irq_stat <= '0;
        end
        else
        begin
            irq_stat <= (rd_irq ? '0 : irq_stat)
                        | {2'h0, 1'b0, 1'b0, revalid_evt}
                        | ({{(DATA_W-1){1'b0}}, failover} << IRQ_FAIL_BIT)
                        | ({{(DATA_W-1){1'b0}}, unlock_cond && !unlock_prev}
                           << IRQ_UNLOCK_BIT);
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I)
        begin
            RDATA_O <= '0;
        end
        else if (RD_I)
        begin
            unique case (ADDR_I)
                OFS_CTRL: RDATA_O <= {refloss_mask, revalid_quad_scale,
                                      revalid_count_sel, holdoff_ref_div_sel,
                                      ref_select_mode};
                OFS_HOLDOFF: RDATA_O <= holdoff_period_value;
                OFS_PWRDN: RDATA_O <= {4'h0, ref_powerdown};
                OFS_STATUS: RDATA_O <= {2'h0, !vcxo_pll_unlock_sticky_n,
                                        unlock_cond, los_flag};
                OFS_IRQ_STAT: RDATA_O <= irq_stat;
                OFS_IRQ_MASK: RDATA_O <= irq_mask;
                default: RDATA_O <= '0; // unmapped reads return zero
            endcase
        end
        else
        begin
            RDATA_O <= '0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign LOS_FLAG_O = los_flag;
    assign REF_PWRDN_O = ref_powerdown;
    assign REF_MODE_O = ref_select_mode;
    assign FAILOVER_O = failover;
    assign UNLOCK_LIVE_N_O = !unlock_cond;
    assign UNLOCK_STICKY_N_O = vcxo_pll_unlock_sticky_n;
    assign LOCK_O = !unlock_cond;
    assign IRQ_O = |(irq_stat & irq_mask);

endmodule : ref_input_revalidation_monitor

/* bench/ref_input_revalidation_monitor_asserts.sv */
/*
 * Port-level checker for the reference input monitor.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/10ps
module ref_input_revalidation_monitor_asserts
    import revalid_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [DATA_W-1:0] RDATA_O,
    input wire logic [NUM_REF-1:0] LOS_EVENT_I,
    input wire logic [NUM_REF-1:0] REF_PERIOD_OK_I,
    input wire logic [NUM_REF-1:0] REF_EDGE_MISS_I,
    input wire logic [1:0] REF_SEL_I,
    input wire logic PLL_UNLOCK_I,
    input wire logic [NUM_REF-1:0] LOS_FLAG_O,
    input wire logic [NUM_REF-1:0] REF_PWRDN_O,
    input wire logic [1:0] REF_MODE_O,
    input wire logic FAILOVER_O,
    input wire logic UNLOCK_LIVE_N_O,
    input wire logic UNLOCK_STICKY_N_O,
    input wire logic LOCK_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    logic mask_q;
    // ----------------------------------------------------------------
    // shadow of the refloss mask, which has no port of its own
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            mask_q <= 1'b0;
        else if (WR_I && ADDR_I == OFS_CTRL)
            mask_q <= WDATA_I[CTRL_MASK_BIT];
    end
    property p_los_set; LOS_EVENT_I[1] |=> LOS_FLAG_O[1]; endproperty
    a_los_set: assert property (p_los_set) else $error("flag not set");
    property p_miss_hold; LOS_FLAG_O[1] && REF_EDGE_MISS_I[1] |=> LOS_FLAG_O[1]; endproperty
    a_miss_hold: assert property (p_miss_hold) else $error("miss released flag");
    property p_clear_cause; $fell(LOS_FLAG_O[1]) |-> $past(REF_PERIOD_OK_I[1]); endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("flag cleared");
    property p_pwrdn_write;
        WR_I && ADDR_I == OFS_PWRDN |=> REF_PWRDN_O == $past(WDATA_I[3:0]);
    endproperty
    a_pwrdn_write: assert property (p_pwrdn_write) else $error("pwrdn write");
    property p_pwrdn_hold; !(WR_I && ADDR_I == OFS_PWRDN) |=> $stable(REF_PWRDN_O); endproperty
    a_pwrdn_hold: assert property (p_pwrdn_hold) else $error("pwrdn moved");
    property p_live;
        UNLOCK_LIVE_N_O == !(PLL_UNLOCK_I || (LOS_FLAG_O[REF_SEL_I] && !mask_q));
    endproperty
    a_live: assert property (p_live) else $error("live unlock wrong");
    property p_lock_pin; LOCK_O == UNLOCK_LIVE_N_O; endproperty
    a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong");
    property p_sticky; !UNLOCK_LIVE_N_O |=> !UNLOCK_STICKY_N_O; endproperty
    a_sticky: assert property (p_sticky) else $error("sticky not set");
    property p_failover;
        FAILOVER_O |-> REF_MODE_O == MODE_AUTO_HOLD ##1 !FAILOVER_O;
    endproperty
    a_failover: assert property (p_failover) else $error("failover pulse");
    property p_rdata_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    c_failover: cover property (FAILOVER_O);
    c_reval: cover property ($fell(LOS_FLAG_O[1]));
    c_irq: cover property ($rose(IRQ_O));
endmodule : ref_input_revalidation_monitor_asserts

/* bench/ref_source_model.sv */
/*
 * Behavioural model of the four reference sources as seen through their
 * edge detectors: one-cycle loss, valid-period and missing-edge pulses.
 * Assumes the bench calls its tasks and nothing else drives these lines.
 */
`timescale 1ns/10ps
module ref_source_model
(
    input wire logic clk_i,
    output logic [3:0] los_o,
    output logic [3:0] ok_o,
    output logic [3:0] miss_o
);
    initial
    begin
        los_o = 4'h0;
        ok_o = 4'h0;
        miss_o = 4'h0;
    end
    // n pulses per call, each followed by an idle cycle so periods never merge
    task automatic pulse(input int kind, input int idx, input int n);
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk_i);
            if (kind == 0) los_o[idx] <= 1'b1;
            if (kind == 1) ok_o[idx] <= 1'b1;
            if (kind == 2) miss_o[idx] <= 1'b1;
            @(posedge clk_i);
            los_o <= 4'h0;
            ok_o <= 4'h0;
            miss_o <= 4'h0;
            #1;
        end
    endtask : pulse
endmodule : ref_source_model

/* bench/ref_input_revalidation_monitor_tb_top.sv */
/*
 * Self-checking bench for the reference input monitor.
 * Assumes the source model above and a free-running VCXO enable.
 */
`timescale 1ns/10ps
module ref_input_revalidation_monitor_tb_top;
    import revalid_pkg::*;
    logic CORE_CLK_I = 1'b0, NRST_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0, PLL_UNLOCK_I = 1'b0;
    logic VCXO_PULSE_I = 1'b1;
    logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00, RDATA_O, rd;
    logic [1:0] REF_SEL_I = 2'h0, REF_MODE_O;
    logic [3:0] LOS_EVENT_I, REF_PERIOD_OK_I, REF_EDGE_MISS_I, LOS_FLAG_O, REF_PWRDN_O;
    logic FAILOVER_O, UNLOCK_LIVE_N_O, UNLOCK_STICKY_N_O, LOCK_O, IRQ_O;
    int errors = 0, checked = 0;
    ref_source_model i_ref_source_model (.clk_i(CORE_CLK_I), .los_o(LOS_EVENT_I),
        .ok_o(REF_PERIOD_OK_I), .miss_o(REF_EDGE_MISS_I));
    ref_input_revalidation_monitor i_ref_input_revalidation_monitor (.CORE_CLK_I(CORE_CLK_I),
        .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .VCXO_PULSE_I(VCXO_PULSE_I), .LOS_EVENT_I(LOS_EVENT_I),
        .REF_PERIOD_OK_I(REF_PERIOD_OK_I), .REF_EDGE_MISS_I(REF_EDGE_MISS_I),
        .REF_SEL_I(REF_SEL_I), .PLL_UNLOCK_I(PLL_UNLOCK_I), .LOS_FLAG_O(LOS_FLAG_O),
        .REF_PWRDN_O(REF_PWRDN_O), .REF_MODE_O(REF_MODE_O), .FAILOVER_O(FAILOVER_O),
        .UNLOCK_LIVE_N_O(UNLOCK_LIVE_N_O), .UNLOCK_STICKY_N_O(UNLOCK_STICKY_N_O),
        .LOCK_O(LOCK_O), .IRQ_O(IRQ_O));
    // ----------------------------------------------------------------
    // clock, bus and compare helpers
    // ----------------------------------------------------------------
    initial
    begin
        forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CORE_CLK_I);
        WR_I <= 1'b0;
        #1;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge CORE_CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CORE_CLK_I);
        RD_I <= 1'b0;
        #1 rd = RDATA_O; // data stand only in this cycle
    endtask : rdr
    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    // ctrl layout: mask, quad, count select, divider select, mode
    function automatic logic [7:0] ctl(logic m, logic q, logic [1:0] c, logic [1:0] d,
                                       logic [1:0] md);
        return {m, q, c, d, md};
    endfunction : ctl
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        rdr(OFS_CTRL); chk("ctrl", 8'h28, rd);
        rdr(OFS_HOLDOFF); chk("holdoff", 8'h80, rd);
        rdr(OFS_PWRDN); chk("pwrdn", 8'h00, rd);
        rdr(OFS_IRQ_MASK); chk("irq mask", 8'h00, rd);
        rdr(8'h3c); chk("unmapped", 8'h00, rd);
    endtask : t_reset_values
    // every count code in both scales, boundary at the last period
    task automatic t_count_table();
        int tbl [8] = '{2, 16, 32, 64, 8, 64, 128, 256};
        for (int k = 0; k < 8; k++)
        begin
            wr(OFS_CTRL, ctl(1'b0, k[2], k[1:0], 2'h2, 2'h0));
            i_ref_source_model.pulse(0, 1, 1);
            i_ref_source_model.pulse(1, 1, tbl[k] - 1);
            chk("flag before last", 1'b1, LOS_FLAG_O[1]);
            i_ref_source_model.pulse(1, 1, 1);
            chk("flag after last", 1'b0, LOS_FLAG_O[1]);
        end
    endtask : t_count_table
    // a missing edge restarts the count; other inputs keep their own state
    task automatic t_miss_reload();
        wr(OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 2'h2, 2'h0));
        i_ref_source_model.pulse(0, 1, 1);
        i_ref_source_model.pulse(0, 3, 1);
        i_ref_source_model.pulse(1, 1, 1);
        i_ref_source_model.pulse(2, 1, 1);
        i_ref_source_model.pulse(1, 1, 1);
        chk("flag after miss", 1'b1, LOS_FLAG_O[1]);
        i_ref_source_model.pulse(1, 1, 1);
        chk("flag reloaded run", 1'b0, LOS_FLAG_O[1]);
        chk("other input", 1'b1, LOS_FLAG_O[3]);
        i_ref_source_model.pulse(1, 3, 2);
        chk("other cleared", 1'b0, LOS_FLAG_O[3]);
    endtask : t_miss_reload
    task automatic t_lock();
        REF_SEL_I <= 2'h2;
        i_ref_source_model.pulse(0, 2, 1);
        chk("lock on ref loss", 1'b0, LOCK_O);
        rdr(OFS_STATUS); chk("status", 8'h34, rd);
        wr(OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 2'h2, 2'h0));
        chk("lock masked", 1'b1, LOCK_O);
        chk("live masked", 1'b1, UNLOCK_LIVE_N_O);
        PLL_UNLOCK_I <= 1'b1;
        @(posedge CORE_CLK_I);
        #1 chk("live pll", 1'b0, UNLOCK_LIVE_N_O);
        PLL_UNLOCK_I <= 1'b0;
        wr(OFS_STATUS, 8'h00);
        chk("sticky cleared", 1'b1, UNLOCK_STICKY_N_O);
        i_ref_source_model.pulse(1, 2, 2);
        wr(OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 2'h2, 2'h0));
        REF_SEL_I <= 2'h0;
    endtask : t_lock
    task automatic t_irq();
        wr(OFS_IRQ_MASK, 8'h02);
        rdr(OFS_IRQ_STAT);
        chk("irq idle", 1'b0, IRQ_O);
        i_ref_source_model.pulse(0, 1, 1);
        i_ref_source_model.pulse(1, 1, 2);
        @(posedge CORE_CLK_I);
        #1 chk("irq raised", 1'b1, IRQ_O);
        rdr(OFS_IRQ_STAT); chk("irq stat", 8'h02, rd);
        chk("irq cleared", 1'b0, IRQ_O);
        wr(OFS_IRQ_MASK, 8'h00);
        i_ref_source_model.pulse(0, 1, 1);
        i_ref_source_model.pulse(1, 1, 3);
        chk("irq masked", 1'b0, IRQ_O);
    endtask : t_irq
    // power-down only in manual mode, where dropping inputs is allowed
    task automatic t_pwrdn();
        wr(OFS_PWRDN, 8'h05);
        chk("pwrdn out", 4'h5, REF_PWRDN_O);
        rdr(OFS_PWRDN); chk("pwrdn read", 8'h05, rd);
        wr(OFS_PWRDN, 8'h00);
        chk("pwrdn off", 4'h0, REF_PWRDN_O);
    endtask : t_pwrdn
    // two fail-overs one tick apart give the exact prescaler period
    task automatic t_holdoff();
        int n;
        wr(OFS_HOLDOFF, 8'h01);
        wr(OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 2'h0, MODE_AUTO_HOLD));
        chk("mode", MODE_AUTO_HOLD, REF_MODE_O);
        for (int r = 0; r < 2; r++)
        begin
            i_ref_source_model.pulse(0, 0, 1);
            n = 2;
            while (FAILOVER_O !== 1'b1 && n < 40000)
            begin
                @(posedge CORE_CLK_I);
                #1 n++;
            end
            if (n >= 40000)
            begin
                chk("failover timeout", 1'b1, 1'b0);
                finish_test();
            end
        end
        chk("tick period", 32'd32768, n);
    endtask : t_holdoff
    initial
    begin
        repeat (4) @(posedge CORE_CLK_I);
        NRST_I <= 1'b1;
        t_reset_values();
        t_count_table();
        t_miss_reload();
        t_lock();
        t_irq();
        t_pwrdn();
        t_holdoff();
        finish_test();
    end
endmodule : ref_input_revalidation_monitor_tb_top
bind ref_input_revalidation_monitor ref_input_revalidation_monitor_asserts
    i_ref_input_revalidation_monitor_asserts (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .LOS_EVENT_I(LOS_EVENT_I), .REF_PERIOD_OK_I(REF_PERIOD_OK_I),
    .REF_EDGE_MISS_I(REF_EDGE_MISS_I), .REF_SEL_I(REF_SEL_I), .PLL_UNLOCK_I(PLL_UNLOCK_I),
    .LOS_FLAG_O(LOS_FLAG_O), .REF_PWRDN_O(REF_PWRDN_O), .REF_MODE_O(REF_MODE_O),
    .FAILOVER_O(FAILOVER_O), .UNLOCK_LIVE_N_O(UNLOCK_LIVE_N_O),
    .UNLOCK_STICKY_N_O(UNLOCK_STICKY_N_O), .LOCK_O(LOCK_O), .IRQ_O(IRQ_O));
